// ### hdl/hbc_host_cycle.sv
// host bus cycle control: slave sampling and owner drive of cycle pins
//
// Summary of operation
// R1: capture space id the cycle after strobe
// R2: ignore id, mask, select while owning bus
// R3: mask low drops top nibble, id decode
// R4: host holds register select low whole access
// R5: drive strobe as owner only in sdram mode
// R6: owner strobe low one clock, first cycle
// R7: host supplies strobe when it owns bus
// R8: owner drives read/write steady whole cycle
// R9: slave samples read/write after strobe
// R10: owner burst request only in sdram mode
// R11: burst request and external request together
// R12: external request drops at first ready
// R13: slave samples burst request, grants if timely
// R14: untimely burst completes as single transfer
// R15: no burst for registers or chip space
// R16: burst ack output on granted slave burst
// R17: inhibit low keeps burst ack high
// R18: ready low when data presented or taken
// R19: ownership flag selects drive or sample
`timescale 1ns/10ps
module hbc_host_cycle
  import hbc_pkg::*;
#(
  parameter int BURST_BEATS = HBC_BURST_BEATS
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // ownership control from the core
  input wire logic own_grant_i,          // bus granted to this block
  input wire logic own_release_i,        // bus handed back to host
  input wire logic sdram_mode_i,         // configuration bit
  // host pins, each passes the synchroniser
  input wire logic addr_strobe_n_i,      // pin
  input wire logic read_write_n_i,       // pin
  input wire logic burst_request_n_i,    // pin
  input wire logic [3:0] space_id_i,     // pin
  input wire logic [3:0] addr_hi_i,      // pin, address 31:28
  input wire logic decode_mask_n_i,      // pin
  input wire logic reg_select_n_i,       // pin
  input wire logic burst_inhibit_n_i,    // pin
  input wire logic ready_in_n_i,         // pin, ready while owner
  // same-clock inputs from the core, read without flops
  input wire logic ecs_hit_i,            // chip space decoder
  input wire logic burst_timing_ok_i,    // alignment allows burst
  input wire logic data_ready_i,         // read data on the bus
  input wire logic data_taken_i,         // write data taken
  // owner cycle requests from the core
  input wire logic mst_start_i,
  input wire logic mst_write_i,
  input wire logic mst_burst_i,
  input wire logic mst_end_i,
  output logic bus_owner_o,
  // owner-side pin drive, oe high while driving
  output logic addr_strobe_n_o,
  output logic addr_strobe_oe_o,
  output logic read_write_n_o,
  output logic read_write_oe_o,
  output logic burst_request_n_o,
  output logic burst_request_oe_o,
  output logic ext_burst_request_n_o,
  // slave-side pin drive
  output logic burst_ack_n_o,
  output logic burst_ack_oe_o,
  output logic ready_n_o,
  output logic ready_oe_o,
  // access report to the core
  output logic acc_valid_o,              // one pulse per slave access
  output logic acc_write_o,
  output logic [1:0] acc_target_o,
  output logic acc_burst_o,
  output logic [3:0] acc_space_id_o
);
  // slave sequence: idle, sample cycle after the strobe, access
  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_ACCESS} hbc_slv_state_type;

  // pin group width and beat counter size
  localparam int PIN_W = 16;             // synchronised pin group
  localparam int BW = $clog2(BURST_BEATS + 1);
  localparam logic [BW-1:0] LAST_BEAT = BW'(BURST_BEATS - 1);

  logic [PIN_W-1:0] pin_raw;             // pins before the synchroniser
  logic [PIN_W-1:0] pin_s;               // pins after two flops
  // synchronised copies of the host pins
  logic as_s, rw_s, br_s, msk_s, rs_s, inh_s, rdy_s;
  logic [3:0] sid_s, ahi_s;
  logic owner_r;                          // ownership flag
  logic as_prev_r;                        // strobe seen last cycle
  hbc_slv_state_type st_r, st_nxt;
  logic write_r, burst_r;
  logic [1:0] tgt_r;
  logic [BW-1:0] beat_r;
  // decode and handshake terms
  logic as_fall, slv_go, id_hit, pci_hit;
  logic [1:0] tgt_nxt;
  logic grant, rdy_evt, last_rdy;

  // carrier to the owner drive module
  hbc_mst_if mif();

  // every host pin passes two flops before any logic reads it
  assign pin_raw = {addr_strobe_n_i, read_write_n_i, burst_request_n_i,
                    decode_mask_n_i, reg_select_n_i, burst_inhibit_n_i,
                    ready_in_n_i, 1'b1, space_id_i, addr_hi_i};

  // the two flops cost two cycles on every strobe; the host holds its
  // qualifiers for the whole access, so they stay aligned with the strobe
  hbc_sync #(.WIDTH(PIN_W), .INIT(16'hff00)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  // unpack the synchronised group
  assign {as_s, rw_s, br_s, msk_s, rs_s, inh_s, rdy_s} = pin_s[15:9];
  assign sid_s = pin_s[7:4];
  assign ahi_s = pin_s[3:0];

  // ownership flag; grant wins when both arrive together
  // the core arbitrates ownership, so a grant is taken at once
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) owner_r <= 1'b0;
    else if (own_grant_i) owner_r <= 1'b1;   // R19
    else if (own_release_i) owner_r <= 1'b0; // R19
  end

  // strobe edge: only meaningful while the host owns the bus
  assign as_fall = as_prev_r && !as_s;
  assign slv_go = as_fall && !owner_r && (st_r == S_IDLE); // R2 R7

  // decode: mask low makes top nibble and id don't-care
  // fixed pci window; a masked host never compares against it
  assign id_hit = (ahi_s == HBC_PCI_AHI) && (sid_s == HBC_PCI_SID);
  assign pci_hit = !msk_s || id_hit;  // R3
  assign tgt_nxt = !rs_s ? HBC_TGT_REG :           // R4
                   ecs_hit_i ? HBC_TGT_ECS :
                   pci_hit ? HBC_TGT_PCI : HBC_TGT_NONE;

  // burst only for pci space, timing ok, not inhibited
  // timing and chip decode come from same-clock logic, so no flops
  assign grant = !br_s && burst_timing_ok_i && inh_s    // R13 R17
                 && (tgt_nxt == HBC_TGT_PCI);            // R15 R14

  // ready for register, chip and pci accesses follows the core handshake
  // a target of none never answers; the host's own timer must end it
  assign rdy_evt = (st_r == S_ACCESS) && (tgt_r != HBC_TGT_NONE)
                   && (write_r ? data_taken_i : data_ready_i); // R18
  assign last_rdy = rdy_evt && (!burst_r || beat_r == LAST_BEAT);

  // slave sequence: strobe seen, sample cycle, access until last ready, or one access cycle for a target of none
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (slv_go) st_nxt = S_SAMPLE;
      S_SAMPLE: st_nxt = S_ACCESS;
      S_ACCESS: if (last_rdy || tgt_r == HBC_TGT_NONE) st_nxt = S_IDLE;
    endcase
  end

  // state and strobe history; history resets to the idle pin level
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= S_IDLE;
      as_prev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      as_prev_r <= as_s;
    end
  end

  // capture in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_r <= 1'b0;
      burst_r <= 1'b0;
      tgt_r <= HBC_TGT_NONE;
      acc_space_id_o <= 4'h0;
    end else if (st_r == S_SAMPLE) begin
      write_r <= !rw_s;            // R9
      burst_r <= grant;            // R13 R14
      tgt_r <= tgt_nxt;
      acc_space_id_o <= sid_s;     // R1
    end
  end

  // beat counter for granted bursts
  // counts readies only; the last one closes the burst
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) beat_r <= '0;
    else if (st_r == S_SAMPLE) beat_r <= '0;
    else if (rdy_evt) beat_r <= beat_r + BW'(1);
  end

  // access report to the core and slave pin drive
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_valid_o <= 1'b0;
      acc_write_o <= 1'b0;
      acc_target_o <= HBC_TGT_NONE;
      acc_burst_o <= 1'b0;
      burst_ack_n_o <= 1'b1;
      burst_ack_oe_o <= 1'b0;
      ready_n_o <= 1'b1;
      ready_oe_o <= 1'b0;
      bus_owner_o <= 1'b0;
    end else begin
      bus_owner_o <= owner_r;
      // pulse for one cycle as the sample cycle ends
      acc_valid_o <= (st_r == S_SAMPLE);
      if (st_r == S_SAMPLE) begin
        acc_write_o <= !rw_s;
        acc_target_o <= tgt_nxt;
        acc_burst_o <= grant;
      end
      // ack held low from sample until the final ready
      if (st_r == S_SAMPLE) burst_ack_n_o <= !grant;   // R16 R17
      else if (st_nxt == S_IDLE) burst_ack_n_o <= 1'b1;
      // ack pin released while this block owns the bus
      burst_ack_oe_o <= !owner_r;                      // R19
      ready_n_o <= !rdy_evt;                           // R18
      // ready pin driven from the sample cycle to the last beat
      ready_oe_o <= (st_nxt != S_IDLE) || (st_r == S_ACCESS);
    end
  end

  // owner-side drive lives in its own module
  assign mif.start = mst_start_i;
  assign mif.write = mst_write_i;
  assign mif.burst = mst_burst_i;
  assign mif.sdram = sdram_mode_i;
  assign mif.ready = !rdy_s;
  assign mif.end_cyc = mst_end_i;
  assign mif.owner = owner_r;

  hbc_mst_drive u_mst (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .m(mif.drv)
  );

  // owner-side pins come straight from flops in the drive module
  assign addr_strobe_n_o = mif.as_n;
  assign addr_strobe_oe_o = mif.as_oe;
  assign read_write_n_o = mif.rw_n;
  assign read_write_oe_o = mif.rw_oe;
  assign burst_request_n_o = mif.br_n;
  assign burst_request_oe_o = mif.br_oe;
  assign ext_burst_request_n_o = mif.ebr_n;

  // checks on the driven side
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sid_capture_a: assert property (st_r == S_SAMPLE |=> acc_space_id_o == $past(sid_s)) // R1
    else $error("space id not captured after strobe");
  owner_ignore_a: assert property ($past(owner_r, 2) |-> !acc_valid_o) // R2
    else $error("slave access started while owner");
  mask_decode_a: assert property (st_r == S_SAMPLE && !msk_s && rs_s && !ecs_hit_i |=> // R3
    acc_target_o == HBC_TGT_PCI) else $error("masked decode not pci");
  as_gate_a: assert property (!sdram_mode_i && $stable(sdram_mode_i) |=> !addr_strobe_oe_o) // R5
    else $error("strobe driven outside sdram mode");
  as_one_clk_a: assert property ($fell(addr_strobe_n_o) |=> addr_strobe_n_o) // R6
    else $error("strobe low longer than one clock");
  rw_hold_a: assert property (mif.busy && $past(mif.busy) && st_r == S_IDLE |-> // R8
    $stable(read_write_n_o)) else $error("read/write changed mid cycle");
  rw_sample_a: assert property (st_r == S_SAMPLE |=> acc_write_o == !$past(rw_s)) // R9
    else $error("read/write sample wrong");
  br_pair_a: assert property (burst_request_n_o == 1'b1 |-> ext_burst_request_n_o) // R11
    else $error("external request without burst request");
  ebr_drop_a: assert property (!ext_burst_request_n_o && mif.ready |=> ext_burst_request_n_o) // R12
    else $error("external request held past first ready");
  no_burst_a: assert property (acc_valid_o && acc_target_o != HBC_TGT_PCI |-> burst_ack_n_o) // R15
    else $error("burst ack for register or chip space");
  inhibit_a: assert property (st_r == S_SAMPLE && !inh_s |=> burst_ack_n_o [*2]) // R17
    else $error("burst ack despite inhibit");
  ready_a: assert property (rdy_evt |=> !ready_n_o) // R18
    else $error("ready missing after data");

  // burst grant, refusal and owner-side pairing
  burst_grant_a: assert property (st_r == S_SAMPLE && grant |=> !burst_ack_n_o && acc_burst_o) // R13
    else $error("granted burst not acknowledged");
  timing_refuse_a: assert property (st_r == S_SAMPLE && !burst_timing_ok_i |=> burst_ack_n_o && !acc_burst_o) // R14
    else $error("burst acknowledged despite timing");
  br_sdram_a: assert property ($fell(burst_request_n_o) |-> $past(sdram_mode_i)) // R10
    else $error("burst request outside sdram mode");
  br_ebr_a: assert property ($fell(burst_request_n_o) |-> $fell(ext_burst_request_n_o)) // R11
    else $error("burst request without external request");
  ack_oe_a: assert property (owner_r |=> !burst_ack_oe_o) // R19
    else $error("burst ack pin driven while owner");

  // main scenarios: granted burst, single register access, owner burst,
  // inhibited burst request and chip space access
  burst_cov_c: cover property (acc_valid_o && acc_burst_o);
  single_cov_c: cover property (acc_valid_o && !acc_burst_o && acc_target_o == HBC_TGT_REG);
  owner_cov_c: cover property ($fell(addr_strobe_n_o) && !burst_request_n_o);
  inhibit_cov_c: cover property (st_r == S_SAMPLE && !br_s && !inh_s);
  ecs_cov_c: cover property (acc_valid_o && acc_target_o == HBC_TGT_ECS);
endmodule : hbc_host_cycle

// ### hdl/hbc_pkg.sv
// constants shared by the host bus cycle control block
package hbc_pkg;
  localparam int HBC_SYNC_STAGES = 2;          // flops in each pin synchroniser
  localparam int HBC_SID_W = 4;                // space identifier width
  localparam int HBC_AHI_W = 4;                // address bits 31:28
  localparam logic [3:0] HBC_PCI_SID = 4'hb;  // space id that maps to pci
  localparam logic [3:0] HBC_PCI_AHI = 4'h8;  // address top nibble for pci
  localparam int HBC_BURST_BEATS = 4;          // ready beats in one burst
  localparam logic [1:0] HBC_TGT_NONE = 2'h0;
  localparam logic [1:0] HBC_TGT_REG = 2'h1;
  localparam logic [1:0] HBC_TGT_PCI = 2'h2;
  localparam logic [1:0] HBC_TGT_ECS = 2'h3;
endpackage : hbc_pkg

// ### hdl/hbc_mst_if.sv
// carrier between the top and its bus-owner drive module
`timescale 1ns/10ps
interface hbc_mst_if;
  logic start;      // begin a bus cycle as owner
  logic write;      // cycle is a write
  logic burst;      // burst conditions met
  logic sdram;      // sdram mode configuration bit
  logic ready;      // synchronised ready from the host side
  logic end_cyc;    // core ends the bus cycle
  logic owner;      // bus-ownership flag
  logic as_n;
  logic as_oe;
  logic rw_n;
  logic rw_oe;
  logic br_n;
  logic br_oe;
  logic ebr_n;
  logic busy;
  modport drv (input start, write, burst, sdram, ready, end_cyc, owner,
               output as_n, as_oe, rw_n, rw_oe, br_n, br_oe, ebr_n, busy);
  modport ctl (output start, write, burst, sdram, ready, end_cyc, owner,
               input as_n, as_oe, rw_n, rw_oe, br_n, br_oe, ebr_n, busy);
endinterface : hbc_mst_if

// ### hdl/hbc_sync.sv
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
module hbc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by the second

  // pins idle high through pull ups; reset loads INIT, the idle level unless the instance sets low bits
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= INIT;
      q_o <= INIT;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : hbc_sync

// ### hdl/hbc_mst_drive.sv
// strobe, read/write and burst request drive while the block owns the bus
`timescale 1ns/10ps
module hbc_mst_drive
  import hbc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  hbc_mst_if.drv m
);
  typedef enum logic [1:0] {M_IDLE, M_FIRST, M_DATA} hbc_mst_state_type;
  hbc_mst_state_type st_r;
  hbc_mst_state_type st_nxt;
  logic go;     // a new cycle may begin
  logic do_br;  // burst request allowed this cycle

  assign go = m.owner && m.start && (st_r == M_IDLE);
  assign do_br = m.burst && m.sdram; // R10

  // next state: first cycle lasts one clock, data phase to end strobe
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      M_IDLE: if (go) st_nxt = M_FIRST;
      M_FIRST: st_nxt = m.end_cyc ? M_IDLE : M_DATA;
      M_DATA: if (m.end_cyc || !m.owner) st_nxt = M_IDLE;
    endcase
  end

  // all pin levels are flops so outputs stay glitch free
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= M_IDLE;
      m.as_n <= 1'b1;
      m.as_oe <= 1'b0;
      m.rw_n <= 1'b1;
      m.rw_oe <= 1'b0;
      m.br_n <= 1'b1;
      m.br_oe <= 1'b0;
      m.ebr_n <= 1'b1;
      m.busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
      m.busy <= (st_nxt != M_IDLE);
      m.as_n <= !(go && m.sdram);        // R6
      m.as_oe <= m.owner && m.sdram;      // R5 R19
      m.rw_oe <= m.owner;                 // R19
      m.br_oe <= m.owner;                 // R19
      if (go) begin
        m.rw_n <= !m.write;               // R8
        m.br_n <= !do_br;                 // R11
        m.ebr_n <= !do_br;                // R11
      end else if (st_nxt == M_IDLE) begin
        m.rw_n <= 1'b1;
        m.br_n <= 1'b1;
        m.ebr_n <= 1'b1;
      end else if (m.ready) begin
        m.ebr_n <= 1'b1;                  // R12
      end
    end
  end
endmodule : hbc_mst_drive

// ### tb/hbc_host_model.sv
// host processor model facing the cycle-control pins
`timescale 1ns/10ps
module hbc_host_model (
  input wire logic clk_sys_i,
  input wire logic rw_oe_i, // block drives read/write as owner
  input wire logic cyc_i, // core starts an owner cycle
  output logic as_n_o,
  output logic rw_n_o,
  output logic br_n_o,
  output logic [3:0] sid_o,
  output logic [3:0] ahi_o,
  output logic mask_n_o,
  output logic rs_n_o,
  output logic inh_n_o,
  output logic rdy_n_o
);
  logic [2:0] pend; // ready answer delay line
  // released pins rest at the pull-up level
  initial begin
    {as_n_o, rw_n_o, br_n_o, mask_n_o, rs_n_o, inh_n_o, rdy_n_o} = '1;
    sid_o = 4'hF;
    ahi_o = 4'hF;
    pend = '0;
  end
  // begin one access: strobe low one clock, qualifiers held to the end
  task automatic start(input logic rw, br, rs, mk, ih, input logic [3:0] sid, ahi);
    @(posedge clk_sys_i);
    as_n_o <= 1'b0;
    rw_n_o <= rw;
    br_n_o <= br;
    rs_n_o <= rs;
    mask_n_o <= mk;
    inh_n_o <= ih;
    sid_o <= sid;
    ahi_o <= ahi;
    @(posedge clk_sys_i);
    as_n_o <= 1'b1;
  endtask : start
  // end of the access: every qualifier goes back to its pull-up
  task automatic finish();
    @(posedge clk_sys_i);
    {rw_n_o, br_n_o, mask_n_o, rs_n_o, inh_n_o} <= '1;
    sid_o <= 4'hF;
    ahi_o <= 4'hF;
  endtask : finish
  // answer each owner cycle with one ready, three clocks after its start request
  always @(posedge clk_sys_i) begin
    pend <= {pend[1:0], cyc_i & rw_oe_i};
    rdy_n_o <= ~pend[2];
  end
endmodule : hbc_host_model

// ### tb/host_bus_cycle_control_bench.sv
// self-checking bench for the host bus cycle control block
`timescale 1ns/10ps
module host_bus_cycle_control_bench
  import hbc_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic grant = 1'b0, rel = 1'b0, sdram = 1'b0, chip = 1'b0, tok = 1'b0;
  logic drdy = 1'b0, dtak = 1'b0, st = 1'b0, wr = 1'b0, bu = 1'b0, en = 1'b0;
  logic as_n, rw_n, br_n, mk_n, rs_n, ih_n, ri_n;
  logic [3:0] sid, ahi;
  logic owner, as_o, as_oe, rw_o, rw_oe, br_o, br_oe, ebr, ack, ack_oe, rdy, rdy_oe;
  logic av, aw, ab;
  logic [1:0] at;
  logic [3:0] asid;
  int mismatches = 0;
  int checks = 0;
  logic [31:0] seed = 32'hd5e7;
  always #2 clk_sys_i = ~clk_sys_i; // 250 MHz
  hbc_host_cycle hbc_host_cycle_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .own_grant_i(grant),
    .own_release_i(rel), .sdram_mode_i(sdram), .addr_strobe_n_i(as_n), .read_write_n_i(rw_n),
    .burst_request_n_i(br_n), .space_id_i(sid), .addr_hi_i(ahi), .decode_mask_n_i(mk_n),
    .reg_select_n_i(rs_n), .burst_inhibit_n_i(ih_n), .ready_in_n_i(ri_n), .ecs_hit_i(chip),
    .burst_timing_ok_i(tok), .data_ready_i(drdy), .data_taken_i(dtak), .mst_start_i(st),
    .mst_write_i(wr), .mst_burst_i(bu), .mst_end_i(en), .bus_owner_o(owner), .addr_strobe_n_o(as_o),
    .addr_strobe_oe_o(as_oe), .read_write_n_o(rw_o), .read_write_oe_o(rw_oe), .burst_request_n_o(br_o),
    .burst_request_oe_o(br_oe), .ext_burst_request_n_o(ebr), .burst_ack_n_o(ack), .burst_ack_oe_o(ack_oe),
    .ready_n_o(rdy), .ready_oe_o(rdy_oe), .acc_valid_o(av), .acc_write_o(aw), .acc_target_o(at),
    .acc_burst_o(ab), .acc_space_id_o(asid));
  hbc_host_model hbc_host_model_inst (.clk_sys_i(clk_sys_i), .rw_oe_i(rw_oe), .as_n_o(as_n), .rw_n_o(rw_n),
    .cyc_i(st), .br_n_o(br_n), .sid_o(sid), .ahi_o(ahi), .mask_n_o(mk_n), .rs_n_o(rs_n),
    .inh_n_o(ih_n), .rdy_n_o(ri_n));
  // next value of the fixed-seed random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // expected decode: register select first, then chip space, then pci match
  function automatic logic [1:0] exp_tgt(input logic rs, ch, mk, input logic [3:0] s, a);
    if (!rs) return HBC_TGT_REG;
    if (ch) return HBC_TGT_ECS;
    if (!mk || (s == HBC_PCI_SID && a == HBC_PCI_AHI)) return HBC_TGT_PCI;
    return HBC_TGT_NONE;
  endfunction : exp_tgt
  // one comparison, counted; a difference is reported at once
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // counts, verdict and end of run
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // wait a bounded time for the access pulse; a long wait means it never came
  task automatic wait_av(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 10 && !seen; i++) begin
      @(posedge clk_sys_i);
      #1 seen = (av === 1'b1);
    end
  endtask : wait_av
  // one slave access: decode, direction, burst grant and ready per beat
  task automatic slave(input logic r, b, rs, ch, mk, ih, t, input logic [3:0] s, a);
    logic seen;
    logic [1:0] et;
    logic eb;
    et = exp_tgt(rs, ch, mk, s, a);
    eb = !b && ih && t && et == HBC_TGT_PCI; // no burst for reg, chip space or inhibit
    chip <= ch;
    tok <= t;
    hbc_host_model_inst.start(r, b, rs, mk, ih, s, a);
    wait_av(seen);
    check(seen, 1);
    check(aw, !r);
    check(at, et);
    check(ab, eb);
    check(asid, s);
    check(ack, !eb);
    check(ack_oe, 1);
    for (int k = 0; k < (et == HBC_TGT_NONE ? 0 : (eb ? HBC_BURST_BEATS : 1)); k++) begin
      @(posedge clk_sys_i);
      drdy <= r;
      dtak <= !r;
      @(posedge clk_sys_i);
      drdy <= 1'b0;
      dtak <= 1'b0;
      #1 check({rdy, rdy_oe}, 2'h1);
    end
    repeat (3) @(posedge clk_sys_i);
    #1 check(ack, 1);
    hbc_host_model_inst.finish();
    chip <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask : slave
  // one owner cycle: strobe only in sdram mode, steady direction, burst pair
  task automatic owner_cyc(input logic w, b, sd);
    logic done;
    @(posedge clk_sys_i);
    sdram <= sd;
    st <= 1'b1;
    wr <= w;
    bu <= b;
    @(posedge clk_sys_i);
    st <= 1'b0;
    #1 check(as_o, !sd);
    check(as_oe, sd);
    check({rw_o, rw_oe, br_oe}, {!w, 2'h3});
    check({br_o, ebr}, {2{!(b && sd)}});
    @(posedge clk_sys_i);
    #1 check(as_o, 1);
    done = 1'b0;
    for (int i = 0; i < 8 && !done; i++) begin
      @(posedge clk_sys_i);
      #1 done = (ebr === 1'b1) && (ri_n === 1'b1) && (i > 3);
      if (i == 2) check(ebr, !(b && sd));
    end
    check(done, 1);
    check(rw_o, !w);
    @(posedge clk_sys_i);
    en <= 1'b1;
    @(posedge clk_sys_i);
    en <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 check(br_o, 1);
  endtask : owner_cyc
  // watchdog: the tests need well under a thousand clocks
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  // main sequence
  initial begin
    logic seen;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    // corner cases: each target, burst refused by inhibit and by timing
    slave(1, 0, 0, 0, 1, 1, 1, 4'h3, 4'h1);
    slave(0, 0, 1, 1, 1, 1, 1, 4'h5, 4'h2);
    slave(1, 0, 1, 0, 1, 1, 1, HBC_PCI_SID, HBC_PCI_AHI);
    slave(1, 0, 1, 0, 1, 0, 1, HBC_PCI_SID, HBC_PCI_AHI);
    slave(0, 0, 1, 0, 1, 1, 0, HBC_PCI_SID, HBC_PCI_AHI);
    slave(0, 1, 1, 0, 0, 1, 1, 4'h2, 4'h7);
    slave(1, 0, 1, 0, 1, 1, 1, 4'h2, 4'h7);
    $display("test slave_corners done");
    for (int n = 0; n < 30; n++) begin
      seed = lfsr(seed);
      slave(seed[0], seed[1], seed[2] | seed[3], seed[4] & seed[5], seed[6] | seed[7], seed[8] | seed[9],
            seed[10], (seed[11] ? HBC_PCI_SID : seed[15:12]), (seed[11] ? HBC_PCI_AHI : seed[19:16]));
    end
    $display("test slave_random done");
    @(posedge clk_sys_i);
    grant <= 1'b1;
    @(posedge clk_sys_i);
    grant <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 check(owner, 1);
    check(ack_oe, 0);
    hbc_host_model_inst.start(1, 0, 0, 0, 0, 4'h3, 4'h1);
    wait_av(seen);
    check(seen, 0);
    hbc_host_model_inst.finish();
    owner_cyc(1, 1, 1);
    owner_cyc(0, 1, 0);
    owner_cyc(0, 0, 1);
    @(posedge clk_sys_i);
    rel <= 1'b1;
    @(posedge clk_sys_i);
    rel <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 check(owner, 0);
    $display("test owner done");
    slave(0, 0, 1, 0, 1, 1, 1, HBC_PCI_SID, HBC_PCI_AHI);
    summarize();
  end
endmodule : host_bus_cycle_control_bench
